//--- rtl/tmr_pkg.sv
package tmr_pkg;

  // register byte offsets on the apb bus
  localparam logic [11:0] OFS_COUNT  = 12'h000;
  localparam logic [11:0] OFS_CONFIG = 12'h004;
  localparam logic [11:0] OFS_INTCTL = 12'h008;

  // config register field positions
  localparam int CFG_RATE_LSB = 0;
  localparam int CFG_BYPASS   = 3;
  localparam int CFG_EDGE     = 4;
  localparam int CFG_SOURCE   = 5;

  // interrupt_control field positions, other bits read as zero
  localparam int ICTL_FLAG = 2;
  localparam int ICTL_IE   = 5;

  // reset values and the count maximum
  localparam logic [7:0] COUNT_RST  = 8'h00;
  localparam logic [7:0] CONFIG_RST = 8'h3f;
  localparam logic [7:0] COUNT_MAX  = 8'hff;

  // instruction cycle timing: four clock phases per instruction cycle
  localparam int         CLK_HZ          = 25_000_000;
  localparam int         PHASES_PER_INSN = 4;
  localparam logic [1:0] PHASE_SECOND    = 2'h1;
  localparam logic [1:0] PHASE_FOURTH    = 2'h3;
  localparam logic [1:0] INHIBIT_INSNS   = 2'h2;
  localparam int         PRESCALE_W      = 8;

  // timer configuration as seen by the counting logic
  typedef struct packed {
    logic       counter_mode;
    logic       falling_edge;
    logic       bypass;
    logic [2:0] rate;
  } tmr_cfg_t;

  // one apb request from the bus master
  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } apb_req_t;

  function automatic tmr_cfg_t cfg_unpack(input logic [7:0] raw);
    tmr_cfg_t c;
    c.counter_mode = raw[CFG_SOURCE];
    c.falling_edge = raw[CFG_EDGE];
    c.bypass       = raw[CFG_BYPASS];
    c.rate         = raw[CFG_RATE_LSB +: 3];
    return c;
  endfunction

endpackage

//--- rtl/tmr_prescaler.sv
`timescale 1ns/1ps
module tmr_prescaler
  import tmr_pkg::*;
#(
  parameter int WIDTH = PRESCALE_W
) (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       clear_in,
  input  wire logic       hold_in,
  input  wire logic       pulse_in,
  input  wire logic [2:0] rate_in,
  output logic            level_out
);

  logic [WIDTH-1:0] div_ff;
  logic [WIDTH-1:0] nxt_div;

  // private divider, the bus reaches it only through the count-write clear; a clear wins over a pulse
  assign nxt_div = clear_in ? '0 :
                   (pulse_in && !hold_in) ? div_ff + 1'b1 : div_ff; // see RULE7 see RULE11 see RULE12

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      div_ff <= '0;
    end else begin
      div_ff <= nxt_div;
    end
  end

  // bit n rises once every 2^(n+1) input pulses
  assign level_out = div_ff[rate_in]; // see RULE8 see RULE9

  a_prescale_clear: assert property (@(posedge clk_in) disable iff (rst_in) // see RULE12
    clear_in |=> div_ff == '0) else $error("prescaler not cleared");

endmodule

//--- rtl/tmr_phase_sync.sv
`timescale 1ns/1ps
module tmr_phase_sync
  import tmr_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic clear_in,
  input  wire logic sample_in,
  input  wire logic level_in,
  output logic      rise_out
);

  logic held_ff;
  logic rise_ff;

  // level is only looked at on the sampling phases, so a short glitch between
  // samples is not counted; the source must stay high and low long enough.
  // history starts high so a level that is already high is never an edge
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      held_ff <= 1'b1;
      rise_ff <= 1'b0;
    end else if (clear_in) begin
      held_ff <= 1'b1;
      rise_ff <= 1'b0;
    end else begin
      rise_ff <= sample_in && level_in && !held_ff; // see RULE6
      if (sample_in) begin
        held_ff <= level_in;
      end
    end
  end

  assign rise_out = rise_ff;

endmodule

//--- rtl/eight_bit_timer_counter.sv
`timescale 1ns/1ps
// Behaviour
// RULE1 - timer mode unscaled: one per instruction cycle
// RULE2 - no counting two cycles after write
// RULE3 - counter mode counts external pin edges
// RULE4 - edge select chooses counted transition
// RULE5 - one counts falling, zero counts rising
// RULE6 - sample prescaler output on phases two, four
// RULE7 - private prescaler used when bypass clear
// RULE8 - rate field picks eight ratios, 2..256
// RULE9 - rate n divides by two^(n+1)
// RULE10 - one-to-one only with bypass set
// RULE11 - prescaler count hidden from software
// RULE12 - count write clears prescaler
// RULE13 - overflow on wrap from max to zero
// RULE14 - flag sets on every wrap, enable ignored
// RULE15 - flag cleared only by software writing zero
// RULE16 - enable bit gates interrupt request
// RULE17 - request equals flag and enable
// RULE18 - sleep stops counting, no wake
// RULE19 - count kept through sleep, resumes after
// RULE20 - overflow pulse offered as gate
module eight_bit_timer_counter
  import tmr_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  input  wire logic [3:0]  pstrb_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        external_count_pin_in,
  input  wire logic        sleep_in,
  output logic      [7:0]  count_out,
  output logic             overflow_irq_out,
  output logic             overflow_gate_out
);

  // bus request bundle
  apb_req_t req;
  assign req = '{sel: psel_in, enable: penable_in, write: pwrite_in,
                 addr: paddr_in, wdata: pwdata_in};

  // state
  logic [7:0] count_register_ff;
  logic [7:0] config_ff;
  logic       overflow_flag_ff;
  logic       overflow_irq_enable_ff;
  logic [1:0] phase_ff;
  logic [1:0] inhibit_ff;
  logic       pin_prev_ff;
  logic       gate_ff;
  logic [31:0] rdata_ff;

  logic [7:0] nxt_count;
  logic [7:0] nxt_config;
  logic       nxt_flag;
  logic       nxt_ie;
  logic [1:0] nxt_inhibit;
  logic [31:0] nxt_rdata;

  // apb decode
  logic hit_count;
  logic hit_config;
  logic hit_intctl;
  logic mapped;
  logic access;
  logic wr_access;
  logic rd_access;
  logic lane0;
  logic wr_count;
  logic wr_config;
  logic wr_intctl;

  // single-cycle access phase: the slave never inserts wait states
  assign hit_count  = (req.addr == OFS_COUNT);
  assign hit_config = (req.addr == OFS_CONFIG);
  assign hit_intctl = (req.addr == OFS_INTCTL);
  assign mapped     = hit_count || hit_config || hit_intctl;
  assign access     = req.sel && req.enable;
  assign wr_access  = access && req.write;
  assign rd_access  = access && !req.write;
  assign lane0      = pstrb_in[0];
  assign wr_count   = wr_access && hit_count && lane0;
  assign wr_config  = wr_access && hit_config && lane0;
  assign wr_intctl  = wr_access && hit_intctl && lane0;

  assign pready_out  = 1'b1;
  assign pslverr_out = access && !mapped; // unmapped answers with an error

  // config view
  tmr_cfg_t cfg;
  assign cfg = cfg_unpack(config_ff);

  // instruction phases
  logic insn_tick;
  logic sample_phase;
  logic running;

  // phase counter also freezes in sleep, so nothing advances at all there
  assign running      = !sleep_in; // see RULE18
  assign insn_tick    = running && (phase_ff == PHASE_FOURTH);
  assign sample_phase = running &&
                        ((phase_ff == PHASE_SECOND) || (phase_ff == PHASE_FOURTH)); // see RULE6

  // count source
  logic pin_norm;
  logic pin_edge;
  logic pre_pulse;
  logic pre_level;
  logic sync_level;
  logic sync_rise;
  logic inc_raw;
  logic inc;
  logic wrap;

  // the edge select inverts the pin so a single rising detector serves both
  assign pin_norm  = external_count_pin_in ^ cfg.falling_edge; // see RULE4 see RULE5
  assign pin_edge  = pin_norm && !pin_prev_ff;
  // the source pulse feeding the divider: pin edges or instruction cycles
  assign pre_pulse = cfg.counter_mode ? pin_edge : insn_tick; // see RULE3

  tmr_prescaler #(
    .WIDTH (PRESCALE_W)
  ) u_prescaler (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .clear_in  (wr_count),
    .hold_in   (sleep_in || cfg.bypass),
    .pulse_in  (pre_pulse),
    .rate_in   (cfg.rate),
    .level_out (pre_level)
  );

  // bypass takes the divider out of the path entirely
  assign sync_level = cfg.bypass ? pin_norm : pre_level; // see RULE7 see RULE10

  tmr_phase_sync u_sync (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .clear_in  (wr_count),
    .sample_in (sample_phase),
    .level_in  (sync_level),
    .rise_out  (sync_rise)
  );

  // timer mode without divider steps every instruction cycle directly;
  // every other path goes through the phase-sampled synchroniser
  assign inc_raw = (!cfg.counter_mode && cfg.bypass) ? insn_tick : sync_rise; // see RULE1
  assign inc     = inc_raw && running && (inhibit_ff == 2'h0) && !wr_count; // see RULE2 see RULE19
  assign wrap    = inc && (count_register_ff == COUNT_MAX); // see RULE13

  // next state
  assign nxt_count = wr_count ? req.wdata[7:0] :
                     inc      ? count_register_ff + 8'h01 : count_register_ff;

  assign nxt_config = wr_config ? req.wdata[7:0] : config_ff;

  // a wrap in the same cycle as a software clear still leaves the flag set
  assign nxt_flag = wrap ? 1'b1 :
                    wr_intctl ? req.wdata[ICTL_FLAG] : overflow_flag_ff; // see RULE14 see RULE15

  assign nxt_ie = wr_intctl ? req.wdata[ICTL_IE] : overflow_irq_enable_ff;

  // the hold is counted in instruction cycles, not in clocks
  assign nxt_inhibit = wr_count ? INHIBIT_INSNS :
                       (insn_tick && (inhibit_ff != 2'h0)) ? inhibit_ff - 2'h1 :
                       inhibit_ff; // see RULE2

  // read data is registered at the access edge; prdata is valid while pready
  logic [31:0] rd_mux;
  assign rd_mux = hit_count  ? {24'h0, count_register_ff} :
                  hit_config ? {24'h0, config_ff} :
                  hit_intctl ? ({24'h0, 8'h00} |
                                (32'(overflow_flag_ff) << ICTL_FLAG) |
                                (32'(overflow_irq_enable_ff) << ICTL_IE)) :
                  32'h0;
  assign nxt_rdata = rd_mux;

  // registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count_register_ff <= COUNT_RST;
      config_ff         <= CONFIG_RST;
    end else begin
      count_register_ff <= nxt_count;
      config_ff         <= nxt_config;
    end
  end

  // interrupt bits
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      overflow_flag_ff       <= 1'b0;
      overflow_irq_enable_ff <= 1'b0;
    end else begin
      overflow_flag_ff       <= nxt_flag;
      overflow_irq_enable_ff <= nxt_ie;
    end
  end

  // phase, inhibit and edge history
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      phase_ff    <= 2'h0;
      inhibit_ff  <= 2'h0;
      pin_prev_ff <= 1'b1; // idle pin level under the reset edge select, no false edge
    end else begin
      phase_ff    <= running ? phase_ff + 2'h1 : phase_ff;
      inhibit_ff  <= nxt_inhibit;
      pin_prev_ff <= pin_norm;
    end
  end

  // gate pulse and read data
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      gate_ff  <= 1'b0;
      rdata_ff <= 32'h0;
    end else begin
      gate_ff  <= wrap; // see RULE20
      rdata_ff <= nxt_rdata;
    end
  end

  // prdata comes from the flop loaded in the setup cycle, so it is steady in access
  assign prdata_out        = rd_access ? rdata_ff : 32'h0;
  assign count_out         = count_register_ff;
  assign overflow_irq_out  = overflow_flag_ff && overflow_irq_enable_ff; // see RULE16 see RULE17
  assign overflow_gate_out = gate_ff;

  // checks; each one names the rule that it guards on its label line
  a_insn_period: assert property ( // see RULE1
    @(posedge clk_in) disable iff (rst_in)
    (insn_tick && !sleep_in) ##1 !sleep_in [*3] |-> ##1 (phase_ff == PHASE_FOURTH))
    else $error("instruction cycle is not four clocks");

  a_timer_step: assert property ( // see RULE1
    @(posedge clk_in) disable iff (rst_in)
    (insn_tick && !cfg.counter_mode && cfg.bypass && inhibit_ff == 2'h0 && !wr_count)
    |=> count_register_ff == $past(count_register_ff) + 8'h01)
    else $error("timer mode did not step");

  a_no_offphase: assert property ( // see RULE1
    @(posedge clk_in) disable iff (rst_in)
    (!cfg.counter_mode && cfg.bypass && !insn_tick && !wr_count) |=> $stable(count_register_ff))
    else $error("timer mode stepped between instruction cycles");

  a_one_step: assert property ( // see RULE1
    @(posedge clk_in) disable iff (rst_in)
    !wr_count |=> (count_register_ff == $past(count_register_ff) ||
                   count_register_ff == $past(count_register_ff) + 8'h01))
    else $error("count moved by more than one");

  a_write_lands: assert property ( // see RULE2
    @(posedge clk_in) disable iff (rst_in)
    wr_count |=> count_register_ff == $past(req.wdata[7:0]))
    else $error("count write did not land");

  a_write_hold: assert property ( // see RULE2
    @(posedge clk_in) disable iff (rst_in)
    wr_count |=> inhibit_ff == INHIBIT_INSNS)
    else $error("write did not start the hold");

  a_inhibit_len: assert property ( // see RULE2
    @(posedge clk_in) disable iff (rst_in)
    wr_count |=> !inc [*5])
    else $error("count stepped too soon after write");

  a_hold_stable: assert property ( // see RULE2
    @(posedge clk_in) disable iff (rst_in)
    (inhibit_ff != 2'h0 && !wr_count) |=> $stable(count_register_ff))
    else $error("count moved during hold");

  a_wrap_flag: assert property ( // see RULE13 see RULE14
    @(posedge clk_in) disable iff (rst_in)
    wrap |=> overflow_flag_ff && count_register_ff == 8'h00)
    else $error("wrap did not set flag");

  a_flag_sticky: assert property ( // see RULE15
    @(posedge clk_in) disable iff (rst_in)
    (overflow_flag_ff && !wr_intctl) |=> overflow_flag_ff)
    else $error("flag cleared by hardware");

  a_flag_clear: assert property ( // see RULE15
    @(posedge clk_in) disable iff (rst_in)
    (wr_intctl && !wrap && !req.wdata[ICTL_FLAG]) |=> !overflow_flag_ff)
    else $error("software clear of flag lost");

  a_ie_write: assert property ( // see RULE16
    @(posedge clk_in) disable iff (rst_in)
    wr_intctl |=> overflow_irq_enable_ff == $past(req.wdata[ICTL_IE]))
    else $error("interrupt enable write lost");

  a_irq_and: assert property ( // see RULE17
    @(posedge clk_in) disable iff (rst_in)
    (wrap && overflow_irq_enable_ff && !wr_intctl) |=> overflow_irq_out)
    else $error("enabled overflow gave no request");

  a_sleep_freeze: assert property ( // see RULE18 see RULE19
    @(posedge clk_in) disable iff (rst_in)
    (sleep_in && !wr_count) |=> $stable(count_register_ff))
    else $error("count moved in sleep");

  a_sleep_phase: assert property ( // see RULE18
    @(posedge clk_in) disable iff (rst_in)
    sleep_in |=> $stable(phase_ff))
    else $error("phase moved in sleep");

  a_gate_pulse: assert property ( // see RULE20
    @(posedge clk_in) disable iff (rst_in)
    wrap |=> overflow_gate_out ##1 !overflow_gate_out [*1])
    else $error("gate pulse not one cycle");

  a_gate_cause: assert property ( // see RULE20
    @(posedge clk_in) disable iff (rst_in)
    overflow_gate_out |-> $past(wrap))
    else $error("gate pulse without a wrap");

endmodule

//--- verif/pulse_source.sv
`timescale 1ns/1ps
// far-side source on the count pin: toggles the pin a requested number of
// times; each level is held HALF clocks so the phase sampler cannot miss it
module pulse_source #(
  parameter int HALF = 4
) (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       start_in,
  input  wire logic [7:0] toggles_in,
  output logic            pin_out,
  output logic            busy_out
);
  logic [7:0] left_ff;
  logic [3:0] wait_ff;

  // a driven source keeps its last level between bursts
  assign busy_out = (left_ff != 8'h00);

  // toggle engine
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      left_ff <= 8'h00;
      wait_ff <= 4'h0;
      pin_out <= 1'b0;
    end else if (start_in && !busy_out) begin
      left_ff <= toggles_in;
      wait_ff <= 4'(HALF);
    end else if (busy_out) begin
      if (wait_ff == 4'h1) begin
        pin_out <= ~pin_out;
        left_ff <= left_ff - 8'h01;
        wait_ff <= 4'(HALF);
      end else begin
        wait_ff <= wait_ff - 4'h1;
      end
    end
  end
endmodule

//--- verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  import tmr_pkg::*;
  logic        clk_in, rst_in, psel, penable, pwrite, pin, sleep, start;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic [3:0]  pstrb;
  logic [7:0]  count, toggles, a;
  logic        pready, pslverr, irq, gate, busy, err_v;
  int          fails, cmp_count;

  eight_bit_timer_counter dut (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .pstrb_in(pstrb), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .external_count_pin_in(pin), .sleep_in(sleep), .count_out(count),
    .overflow_irq_out(irq), .overflow_gate_out(gate));
  pulse_source src (.clk_in(clk_in), .rst_in(rst_in), .start_in(start),
    .toggles_in(toggles), .pin_out(pin), .busy_out(busy));

  task automatic tally_and_finish();
    $display("mismatches %0d, comparisons %0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d,
                     input logic [3:0] s);
    int i;
    @(posedge clk_in);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= ad; pwdata <= d; pstrb <= s;
    @(posedge clk_in);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk_in);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      fails++;
      tally_and_finish();
    end
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d, 4'hf);
  endtask

  task automatic rdchk(input logic [11:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0, 4'hf);
    chk(rd_v, exp);
  endtask

  // settle after edges so register outputs are looked at once they land
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  // ask the partner for a burst and wait, bounded, until it has finished
  task automatic tog(input logic [7:0] n);
    int i;
    @(posedge clk_in);
    start <= 1'b1; toggles <= n;
    @(posedge clk_in);
    start <= 1'b0;
    for (i = 0; i < 400; i++) begin
      @(posedge clk_in);
      if (busy === 1'b0) break;
    end
    if (i == 400) begin
      fails++;
      tally_and_finish();
    end
    wait_n(16);
  endtask

  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  initial begin
    int i;
    rst_in = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; pstrb = 4'h0; sleep = 1'b0; start = 1'b0; toggles = 8'h00;
    fails = 0; cmp_count = 0;
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    // reset values, refused and strobe-less accesses
    rdchk(OFS_COUNT, 32'h0);
    rdchk(OFS_CONFIG, 32'h3f);
    rdchk(OFS_INTCTL, 32'h0);
    apb(1'b0, 12'h00c, 32'h0, 4'hf);
    chk({err_v, rd_v[30:0]}, 32'h80000000);
    apb(1'b1, OFS_CONFIG, 32'h08, 4'h0);
    rdchk(OFS_CONFIG, 32'h3f);
    chk(count, 8'h00);
    // timer mode, bypassed: inhibit after a write, then one per cycle
    wr(OFS_CONFIG, 32'h08);
    wr(OFS_COUNT, 32'h20);
    wait_n(40);
    chk(count, 8'h28);
    wait_n(40);
    chk(count, 8'h32);
    // wrap with interrupt disabled, then flag handling by software
    wr(OFS_COUNT, 32'hfc);
    for (i = 0; i < 40 && gate !== 1'b1; i++) wait_n(1);
    chk({gate, count}, 9'h100);
    rdchk(OFS_INTCTL, 32'h04);
    chk(irq, 1'b0);
    wait_n(20);
    rdchk(OFS_INTCTL, 32'h04);
    wr(OFS_INTCTL, 32'hff);
    rdchk(OFS_INTCTL, 32'h24);
    chk(irq, 1'b1);
    wr(OFS_INTCTL, 32'h20);
    rdchk(OFS_INTCTL, 32'h20);
    chk(irq, 1'b0);
    // a wrap with the request enabled raises it together with the gate pulse
    wr(OFS_COUNT, 32'hfc);
    for (i = 0; i < 40 && gate !== 1'b1; i++) wait_n(1);
    chk({irq, gate}, 2'h3);
    wr(OFS_INTCTL, 32'h00);
    rdchk(OFS_INTCTL, 32'h00);
    // sleep freezes the count, which then resumes from the held value
    @(posedge clk_in);
    sleep <= 1'b1;
    wait_n(2);
    a = count;
    wait_n(40);
    chk(count, a);
    @(posedge clk_in);
    sleep <= 1'b0;
    wait_n(4);
    a = count;
    wait_n(40);
    chk(count - a, 8'h0a);
    // every prescale rate, measured over two whole divided periods
    for (i = 0; i < 8; i++) begin
      wr(OFS_CONFIG, 32'(i));
      wr(OFS_COUNT, 32'h0);
      wait_n(16);
      a = count;
      wait_n(2 * (4 << (i + 1)));
      chk(count - a, 8'h02);
    end
    // counter mode: rising edges, then falling edges, then prescaled
    wr(OFS_CONFIG, 32'h28);
    wr(OFS_COUNT, 32'h0);
    wait_n(16);
    a = count;
    tog(8'h01);
    chk(count - a, 8'h01);
    tog(8'h01);
    chk(count - a, 8'h01);
    wr(OFS_CONFIG, 32'h38);
    wait_n(16);
    a = count;
    tog(8'h01);
    chk(count - a, 8'h00);
    tog(8'h01);
    chk(count - a, 8'h01);
    wr(OFS_CONFIG, 32'h30);
    wait_n(16);
    a = count;
    tog(8'h08);
    chk(count - a, 8'h02);
    tally_and_finish();
  end
endmodule
